// ---- host_tf.sv ----
/* host task-file model: issues one command per call.
   assumes the bench calls send only while the block is idle. */
`timescale 1ns/1ns
module host_tf (
    input wire logic clk_i, // controller clock
    output logic v_o,       // command strobe
    output logic [7:0] c_o, // command
    output logic [7:0] f_o, // feature
    output logic [7:0] s_o, // sector count
    output logic [31:0] a_o // head, cyl high, cyl low, sector
);
    initial begin
        v_o = 1'b0;
        {c_o, f_o, s_o, a_o} = '0;
    end
    task automatic send(input logic [7:0] c, f, s, input logic [27:0] a);
        @(posedge clk_i);
        #1;
        v_o = 1'b1;
        {c_o, f_o, s_o} = {c, f, s};
        a_o = {4'hE, a};
        @(posedge clk_i);
        #1;
        v_o = 1'b0;
        // released bytes must not look valid
        {c_o, f_o, s_o, a_o} = ~{c_o, f_o, s_o, a_o};
    endtask : send
endmodule : host_tf

// ---- id_word_store.sv ----
/*
 * Six-word store for the capacity words of the identify data
 * (words 60, 61, 100..103 at indices 0..5).
 * Assumes one writer and one reader on the same clock; read data are
 * registered, so a read shows one cycle after its address.
 */
`timescale 1ns/1ns
`include "max_address_limit_map.svh"

module id_word_store (
    input wire logic ref_clk_i,            // controller clock
    input wire logic srst_i,               // synchronous reset, high
    input wire logic wr_en_i,              // write strobe
    input wire mac_pkg::id_idx_t wr_idx_i, // write index
    input wire mac_pkg::id_word_t wr_data_i, // write data
    input wire mac_pkg::id_idx_t rd_idx_i, // read index
    output mac_pkg::id_word_t rd_data_o    // registered read data
);
    import mac_pkg::*;

    id_word_t mem_reg [0:5];
    id_word_t rd_data_reg;

    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i && wr_idx_i <= `MAC_ID_IDX_LAST) begin
            mem_reg[wr_idx_i] <= wr_data_i;
        end
    end

    // out-of-range reads return zero rather than an undefined word
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rd_data_reg <= `MAC_ID_WORD_ZERO;
        end else if (rd_idx_i <= `MAC_ID_IDX_LAST) begin
            rd_data_reg <= mem_reg[rd_idx_i];
        end else begin
            rd_data_reg <= `MAC_ID_WORD_ZERO;
        end
    end

    assign rd_data_o = rd_data_reg;

endmodule : id_word_store

// ---- mac_pkg.sv ----
/*
 * Types shared by the maximum-address limit command block.
 * Assumes the constant header is on the include path.
 */
package mac_pkg;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef logic [47:0] lba_t;
    typedef logic [27:0] lba28_t;
    typedef logic [15:0] id_word_t;
    typedef logic [2:0] id_idx_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_CHECK = 4'b0010,
        ST_IDWR  = 4'b0100,
        ST_DONE  = 4'b1000
    } mac_state_t;

endpackage : mac_pkg

// ---- max_address_limit_command.sv ----
/*
 * Maximum-address limit command handling: address-limit versus security
 * subcommand decode, lock/freeze/persistence checks, new limit storage,
 * access screening and identify capacity words.
 * Assumes task-file fields and access requests come from logic on the same
 * clock; the media store of the saved limit and the password compare live
 * outside and are reached through the nv_ and pwd_ ports.
 */
// Overview of operation
// - Max-address command is an address command only right after read-native-max.
// - Otherwise the feature byte selects set password, lock, unlock or freeze.
// - Host keeps the request within native capacity; device replaces its limit.
// - After a new limit, any access above it is aborted.
// - A second nonvolatile limit command aborts until power-on or hardware reset.
// - The command aborts while locked or frozen.
// - Identify words 61:60 report the newly set limit.
// - With 48-bit addressing, words 103:100 carry the same value.
// - Request of 268,435,455 on larger drive keeps native limit, words differ.
// - The command aborts once an extended protected area exists.
// - Sector count bit 0 chooses nonvolatile or volatile limit.
// - Nonvolatile choice is invalid in address offset mode.
// - Device returns the set limit in those same register positions.
`timescale 1ns/1ns
`include "max_address_limit_map.svh"

module max_address_limit_command (
    input wire logic ref_clk_i,                 // 50 MHz controller clock
    input wire logic srst_i,                    // power-on reset, sync, high
    input wire logic hw_rst_i,                  // hardware reset, sync, high
    input wire logic cmd_valid_i,               // task-file command strobe
    input wire logic [7:0] cmd_code_i,          // command register
    input wire logic [7:0] feature_i,           // feature register
    input wire logic [7:0] sector_count_i,      // sector count register
    input wire logic [7:0] sector_number_i,     // sector number register
    input wire logic [7:0] cyl_low_i,           // cylinder low register
    input wire logic [7:0] cyl_high_i,          // cylinder high register
    input wire logic [7:0] dev_head_i,          // device/head register
    input wire mac_pkg::lba_t native_max_i,     // native maximum lba
    input wire logic lba48_supported_i,         // 48-bit addressing present
    input wire logic offset_mode_i,             // address offset mode active
    input wire logic hpa_ext_set_i,             // area set by extended form
    input wire logic pwd_match_i,               // unlock password matched
    input wire logic nv_have_i,                 // saved limit present
    input wire mac_pkg::lba_t nv_lba_i,         // saved limit from media
    input wire logic acc_valid_i,               // media access request
    input wire mac_pkg::lba_t acc_lba_i,        // access lba
    input wire mac_pkg::id_idx_t id_idx_i,      // identify capacity word index
    output logic cmd_done_o,                    // completion pulse
    output logic [7:0] error_flags_o,           // error register
    output logic [7:0] status_flags_o,          // status register
    output logic [7:0] sector_number_o,         // returned lba 7:0
    output logic [7:0] cyl_low_o,               // returned lba 15:8
    output logic [7:0] cyl_high_o,              // returned lba 23:16
    output logic [7:0] dev_head_o,              // returned head nibble
    output mac_pkg::lba_t max_lba_o,            // current limit
    output logic acc_abort_o,                   // access rejected pulse
    output logic sub_cmd_valid_o,               // security subcommand pulse
    output logic [7:0] sub_cmd_o,               // security subcommand code
    output logic nv_write_o,                    // store limit to media pulse
    output mac_pkg::lba_t nv_lba_o,             // limit to store
    output logic locked_o,                      // security locked state
    output logic frozen_o,                      // security frozen state
    output mac_pkg::id_word_t id_data_o         // identify capacity word
);
    import mac_pkg::*;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic above(input lba_t a, input lba_t lim);
        above = (a > lim);
    endfunction : above

    function automatic lba28_t cap28(input lba_t v);
        cap28 = (v > `MAC_LBA28_MAX) ? lba28_t'(`MAC_LBA28_MAX) : v[27:0];
    endfunction : cap28

    function automatic id_word_t id_word(input id_idx_t idx, input logic [31:0] v28,
                                         input logic [63:0] v48);
        case (idx)
            3'h0: id_word = v28[15:0];
            3'h1: id_word = v28[31:16];
            3'h2: id_word = v48[15:0];
            3'h3: id_word = v48[31:16];
            3'h4: id_word = v48[47:32];
            default: id_word = v48[63:48];
        endcase
    endfunction : id_word

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic rst_any;
    mac_state_t state_reg;
    mac_state_t state_next;
    lba_t max_lba_reg;
    lba_t load_lba;
    lba28_t req_reg;
    logic nv_req_reg;
    logic [3:0] dh_hi_reg;
    logic rnm_flag_reg;
    logic nv_done_reg;
    logic locked_reg;
    logic frozen_reg;
    logic init_reg;
    logic abort_reg;
    logic abort_next;
    logic clamp;
    lba_t new_max;
    logic [31:0] id28_reg;
    logic [63:0] id48_reg;
    id_idx_t idx_reg;
    logic finish;
    logic take_rnm;
    logic take_addr;
    logic take_sub;
    logic [7:0] status_reg;
    logic [7:0] error_reg;
    lba28_t ret_reg;
    logic acc_abort_reg;
    logic sub_valid_reg;
    logic [7:0] sub_code_reg;
    logic nv_write_reg;

    assign rst_any = srst_i | hw_rst_i;
    assign load_lba = nv_have_i ? nv_lba_i : native_max_i;
    assign take_rnm = state_reg == ST_IDLE && cmd_valid_i && cmd_code_i == `MAC_CMD_READ_NATIVE;
    assign take_addr = state_reg == ST_IDLE && cmd_valid_i && cmd_code_i == `MAC_CMD_SET_MAX
                       && rnm_flag_reg;
    assign take_sub = state_reg == ST_IDLE && cmd_valid_i && cmd_code_i == `MAC_CMD_SET_MAX
                      && !rnm_flag_reg;

    // ------------------------------------------------------------------
    // request checks
    // ------------------------------------------------------------------
    always_comb begin
        abort_next = locked_reg || frozen_reg;
        abort_next = abort_next || hpa_ext_set_i;
        abort_next = abort_next || above(lba_t'(req_reg), native_max_i);
        abort_next = abort_next || (nv_req_reg && nv_done_reg);
        abort_next = abort_next || (nv_req_reg && offset_mode_i);
        // a 28-bit ceiling request on a bigger drive means "use it all"
        clamp = lba_t'(req_reg) == `MAC_LBA28_MAX && above(native_max_i, `MAC_LBA28_MAX);
        new_max = clamp ? native_max_i : lba_t'(req_reg);
    end

    assign finish = take_rnm || (state_reg == ST_CHECK && abort_next)
                    || (state_reg == ST_IDWR && idx_reg == `MAC_ID_IDX_LAST && !init_reg);

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take_rnm) begin
                    state_next = ST_DONE;
                end else if (take_addr) begin
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: state_next = abort_next ? ST_DONE : ST_IDWR;
            ST_IDWR: begin
                if (idx_reg == `MAC_ID_IDX_LAST) begin
                    state_next = init_reg ? ST_IDLE : ST_DONE;
                end
            end
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // reset walks the identify words once so they match the loaded limit
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            state_reg <= ST_IDWR;
            init_reg <= 1'b1;
            idx_reg <= `MAC_ID_IDX_W60;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDWR) begin
                idx_reg <= idx_reg + `MAC_ID_IDX_ONE;
            end else begin
                idx_reg <= `MAC_ID_IDX_W60;
            end
            if (state_reg == ST_IDWR && idx_reg == `MAC_ID_IDX_LAST) begin
                init_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // command latch and history flags
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            req_reg <= '0;
            nv_req_reg <= 1'b0;
            dh_hi_reg <= '0;
        end else if (take_addr) begin
            req_reg <= {dev_head_i[`MAC_DH_NIB_MSB:0], cyl_high_i, cyl_low_i, sector_number_i};
            nv_req_reg <= sector_count_i[`MAC_SC_NV_BIT];
            dh_hi_reg <= dev_head_i[`MAC_DH_HI_MSB:`MAC_DH_HI_LSB];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            rnm_flag_reg <= 1'b0;
        end else if (take_rnm) begin
            rnm_flag_reg <= 1'b1;
        end else if (cmd_valid_i && state_reg == ST_IDLE) begin
            rnm_flag_reg <= 1'b0;
        end
    end

    // only power-on or hardware reset re-arms the nonvolatile path
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            nv_done_reg <= 1'b0;
        end else if (state_reg == ST_CHECK && !abort_next && nv_req_reg) begin
            nv_done_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // security subcommands
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            locked_reg <= 1'b0;
            frozen_reg <= 1'b0;
            sub_valid_reg <= 1'b0;
            sub_code_reg <= `MAC_BYTE_ZERO;
        end else begin
            sub_valid_reg <= take_sub;
            if (take_sub) begin
                sub_code_reg <= feature_i;
                case (feature_i)
                    `MAC_SUB_LOCK: locked_reg <= !frozen_reg;
                    `MAC_SUB_UNLOCK: locked_reg <= locked_reg && !pwd_match_i;
                    `MAC_SUB_FREEZE: begin
                        frozen_reg <= 1'b1;
                        locked_reg <= 1'b0;
                    end
                    default: locked_reg <= locked_reg;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // limit store and identify values
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            max_lba_reg <= load_lba;
            id28_reg <= {4'h0, cap28(load_lba)};
            id48_reg <= lba48_supported_i ? {16'h0000, load_lba} : 64'h0000_0000_0000_0000;
            nv_write_reg <= 1'b0;
        end else begin
            nv_write_reg <= 1'b0;
            if (state_reg == ST_CHECK && !abort_next) begin
                max_lba_reg <= new_max;
                id28_reg <= {4'h0, req_reg};
                id48_reg <= lba48_supported_i ? {16'h0000, new_max} : 64'h0000_0000_0000_0000;
                nv_write_reg <= nv_req_reg;
            end
        end
    end

    id_word_store u_id_store (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .wr_en_i(state_reg == ST_IDWR),
        .wr_idx_i(idx_reg),
        .wr_data_i(id_word(idx_reg, id28_reg, id48_reg)),
        .rd_idx_i(id_idx_i),
        .rd_data_o(id_data_o)
    );

    // ------------------------------------------------------------------
    // access screening
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            acc_abort_reg <= 1'b0;
        end else begin
            acc_abort_reg <= acc_valid_i && above(acc_lba_i, max_lba_reg);
        end
    end

    // ------------------------------------------------------------------
    // completion registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            status_reg <= `MAC_STAT_RESET;
            error_reg <= `MAC_ERR_RESET;
            abort_reg <= 1'b0;
            ret_reg <= '0;
        end else if (take_addr) begin
            status_reg[`MAC_STAT_BSY_BIT] <= 1'b1;
        end else if (finish) begin
            abort_reg <= state_reg == ST_CHECK;
            status_reg <= `MAC_STAT_RESET;
            status_reg[`MAC_STAT_ERR_BIT] <= state_reg == ST_CHECK;
            error_reg <= `MAC_ERR_RESET;
            error_reg[`MAC_ERR_ABT_BIT] <= state_reg == ST_CHECK;
            // a set-max return is the limit in force, whether or not we aborted; read native returns the native maximum
            ret_reg <= take_rnm ? cap28(native_max_i) : cap28(max_lba_reg);
        end
    end

    assign cmd_done_o = state_reg == ST_DONE;
    assign error_flags_o = error_reg;
    assign status_flags_o = status_reg;
    assign sector_number_o = ret_reg[7:0];
    assign cyl_low_o = ret_reg[15:8];
    assign cyl_high_o = ret_reg[23:16];
    assign dev_head_o = {dh_hi_reg, ret_reg[27:24]};
    assign max_lba_o = max_lba_reg;
    assign acc_abort_o = acc_abort_reg;
    assign sub_cmd_valid_o = sub_valid_reg;
    assign sub_cmd_o = sub_code_reg;
    assign nv_write_o = nv_write_reg;
    assign nv_lba_o = max_lba_reg;
    assign locked_o = locked_reg;
    assign frozen_o = frozen_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i || hw_rst_i);

    a_addr_after_rnm: assert property (take_addr |=> state_reg == ST_CHECK)
        else $error("address command not checked after read native");
    a_sub_without_rnm: assert property (take_sub |=> sub_cmd_valid_o && sub_cmd_o == $past(feature_i))
        else $error("subcommand not forwarded");
    a_limit_replace: assert property (state_reg == ST_CHECK && !abort_next && !clamp
        |=> max_lba_o == lba_t'($past(req_reg)))
        else $error("limit not replaced");
    a_access_above: assert property (acc_valid_i && acc_lba_i > max_lba_o |=> acc_abort_o)
        else $error("access above limit not aborted");
    a_access_within: assert property (acc_valid_i && acc_lba_i <= max_lba_o |=> !acc_abort_o)
        else $error("access within limit aborted");
    a_nv_second: assert property (state_reg == ST_CHECK && nv_req_reg && nv_done_reg
        |=> cmd_done_o && error_flags_o[`MAC_ERR_ABT_BIT])
        else $error("second nonvolatile command accepted");
    a_lock_abort: assert property (state_reg == ST_CHECK && (locked_reg || frozen_reg)
        |=> cmd_done_o && status_flags_o[`MAC_STAT_ERR_BIT])
        else $error("command accepted while locked or frozen");
    a_hpa_abort: assert property (state_reg == ST_CHECK && hpa_ext_set_i |=> abort_reg)
        else $error("command accepted over extended area");
    a_offset_nv: assert property (state_reg == ST_CHECK && nv_req_reg && offset_mode_i |=> abort_reg)
        else $error("nonvolatile accepted in offset mode");
    a_clamp_native: assert property (state_reg == ST_CHECK && !abort_next && clamp
        |=> max_lba_o == $past(native_max_i) && id28_reg == {4'h0, lba28_t'(`MAC_LBA28_MAX)})
        else $error("28-bit ceiling request not widened");
    a_id_low_word: assert property (state_reg == ST_IDWR && idx_reg == `MAC_ID_IDX_W61 && !init_reg
        |=> u_id_store.mem_reg[`MAC_ID_IDX_W61] == {4'h0, req_reg[27:16]})
        else $error("identify word 61 wrong");
    a_ok_done_bound: assert property (state_reg == ST_CHECK && !abort_next
        |-> ##[7:7] cmd_done_o && !error_flags_o[`MAC_ERR_ABT_BIT])
        else $error("identify update did not complete in time");
    a_return_regs: assert property (cmd_done_o && !abort_reg && !$past(take_rnm, 1)
        |-> {dev_head_o[3:0], cyl_high_o, cyl_low_o, sector_number_o} == cap28(max_lba_o))
        else $error("returned limit differs");
    a_rnm_clear: assert property (cmd_valid_i && state_reg == ST_IDLE && cmd_code_i != `MAC_CMD_READ_NATIVE
        |=> !rnm_flag_reg)
        else $error("read native flag not cleared");

    c_addr_ok: cover property (state_reg == ST_CHECK && !abort_next ##7 cmd_done_o);
    c_addr_abort: cover property (state_reg == ST_CHECK && abort_next);
    c_subcmd: cover property (take_sub && feature_i == `MAC_SUB_LOCK);
    c_acc_abort: cover property (acc_abort_o);

endmodule : max_address_limit_command

// ---- max_address_limit_map.svh ----
/*
 * Constants for the maximum-address limit command block: command codes,
 * subcommand codes, task-file field positions, status and error bits,
 * identify-word indices.
 * Assumes it is included by its bare name by the identify word store and the design.
 */
`ifndef MAX_ADDRESS_LIMIT_MAP_SVH
`define MAX_ADDRESS_LIMIT_MAP_SVH

// ----------------------------------------------------------------------
// command and subcommand codes
// ----------------------------------------------------------------------
`define MAC_CMD_SET_MAX 8'hF9
`define MAC_CMD_READ_NATIVE 8'hF8
`define MAC_SUB_SET_PWD 8'h01
`define MAC_SUB_LOCK 8'h02
`define MAC_SUB_UNLOCK 8'h03
`define MAC_SUB_FREEZE 8'h04

// ----------------------------------------------------------------------
// task-file fields
// ----------------------------------------------------------------------
`define MAC_SC_NV_BIT 0
`define MAC_DH_NIB_MSB 3
`define MAC_DH_HI_MSB 7
`define MAC_DH_HI_LSB 4

// ----------------------------------------------------------------------
// status and error flags
// ----------------------------------------------------------------------
`define MAC_ERR_ABT_BIT 2
`define MAC_STAT_BSY_BIT 7
`define MAC_STAT_RDY_BIT 6
`define MAC_STAT_ERR_BIT 0
`define MAC_STAT_RESET 8'h40
`define MAC_ERR_RESET 8'h00
`define MAC_BYTE_ZERO 8'h00

// ----------------------------------------------------------------------
// capacity limits and identify words
// ----------------------------------------------------------------------
`define MAC_LBA28_MAX 48'h0000_0FFF_FFFF
`define MAC_LBA_ZERO 48'h0000_0000_0000
`define MAC_ID_IDX_W60 3'h0
`define MAC_ID_IDX_W61 3'h1
`define MAC_ID_IDX_W100 3'h2
`define MAC_ID_IDX_LAST 3'h5
`define MAC_ID_IDX_ONE 3'h1
`define MAC_ID_WORD_ZERO 16'h0000

`endif

// ---- tb_max_address_limit_command.sv ----
/* self-checking bench for the limit command block.
   assumes host_tf drives the task file. */
`timescale 1ns/1ns
module tb_max_address_limit_command;
    import mac_pkg::*;
    localparam lba_t NAT = 48'h0000_1000_0000;
    logic clk, srst, hw, ofs, nvw, v, pwd, hpa, acc_v, done, ab, sv, lk, fz;
    logic [7:0] c, f, s, err, st, sn, cl, ch, dh, sub;
    logic [31:0] a;
    logic [31:0] lf = 32'h0000_0b53;
    logic [27:0] req;
    lba_t acc, mx, nvl;
    lba_t exp_max = NAT;
    id_idx_t idx;
    id_word_t idd;
    int n_mismatch = 0;
    int compares = 0;
    int n_nvw = 0;
    host_tf host_u (.clk_i(clk), .v_o(v), .c_o(c), .f_o(f), .s_o(s), .a_o(a));
    max_address_limit_command dut_u (.ref_clk_i(clk), .srst_i(srst), .hw_rst_i(hw),
        .cmd_valid_i(v), .cmd_code_i(c), .feature_i(f), .sector_count_i(s), .sector_number_i(a[7:0]),
        .cyl_low_i(a[15:8]), .cyl_high_i(a[23:16]), .dev_head_i(a[31:24]), .native_max_i(NAT),
        .lba48_supported_i(1'b1), .offset_mode_i(ofs), .hpa_ext_set_i(hpa), .pwd_match_i(pwd),
        .nv_have_i(1'b0), .nv_lba_i(48'h0000_0000_0000), .acc_valid_i(acc_v), .acc_lba_i(acc),
        .id_idx_i(idx), .cmd_done_o(done), .error_flags_o(err), .status_flags_o(st), .sector_number_o(sn),
        .cyl_low_o(cl), .cyl_high_o(ch), .dev_head_o(dh), .max_lba_o(mx), .acc_abort_o(ab),
        .sub_cmd_valid_o(sv), .sub_cmd_o(sub), .nv_write_o(nvw), .nv_lba_o(nvl), .locked_o(lk),
        .frozen_o(fz), .id_data_o(idd));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // one count per store-to-media pulse
    always @(posedge clk) begin
        if (nvw === 1'b1) n_nvw++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input lba_t got, input lba_t exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wd();
        for (int i = 0; i < 20 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(done, 1'b1);
    endtask : wd
    task automatic setmax(input logic [7:0] nv, input logic [27:0] r, input logic ok);
        host_u.send(8'hF8, 8'h00, 8'h00, 28'h000_0000);
        wd();
        host_u.send(8'hF9, 8'h00, nv, r);
        wd();
        if (ok) exp_max = (r == 28'hFFF_FFFF) ? NAT : {20'h0_0000, r};
        chk(err, {5'h00, ~ok, 2'h0});
        chk(mx, exp_max);
        chk(nvl, exp_max);
        chk(st, {2'b01, 5'h00, ~ok});
        chk({dh[3:0], ch, cl, sn}, (exp_max > 48'h0000_0FFF_FFFF) ? 28'hFFF_FFFF : exp_max[27:0]);
    endtask : setmax
    task automatic idw(input id_idx_t i, input id_word_t w);
        idx = i;
        @(posedge clk);
        #1;
        chk(idd, w);
    endtask : idw
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        {srst, hw, ofs, pwd, hpa, acc_v, acc, idx} = {1'b1, 56'h0};
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(mx, NAT);
        chk(st, 8'h40);
        lf = lfsr(lf);
        req = lf[27:0] & 28'h7FF_FFFF;
        setmax(8'h00, req, 1'b1);
        idw(3'h0, req[15:0]);
        idw(3'h1, {4'h0, req[27:16]});
        idw(3'h2, req[15:0]);
        $display("test volatile done");
        acc_v = 1'b1;
        for (int k = 0; k < 2; k++) begin
            acc = exp_max + 48'h0000_0000_0001 - 48'(k);
            @(posedge clk);
            #1;
            chk(ab, k == 0);
        end
        acc_v = 1'b0;
        setmax(8'h01, req - 28'h000_0001, 1'b1);
        setmax(8'h01, req, 1'b0);
        hw = 1'b1;
        @(posedge clk);
        #1;
        hw = 1'b0;
        exp_max = NAT;
        repeat (6) @(posedge clk);
        #1;
        chk(mx, NAT);
        ofs = 1'b1;
        setmax(8'h01, req, 1'b0);
        ofs = 1'b0;
        setmax(8'h01, req, 1'b1);
        chk(n_nvw, 2);
        setmax(8'h00, 28'hFFF_FFFF, 1'b1);
        idw(3'h1, 16'h0FFF);
        idw(3'h3, 16'h1000);
        hpa = 1'b1;
        setmax(8'h00, req, 1'b0);
        hpa = 1'b0;
        $display("test limits done");
        for (logic [7:0] j = 8'h01; j < 8'h05; j++) begin
            pwd = 1'b1;
            host_u.send(8'hF9, j, 8'h00, 28'h000_0000);
            chk({sv, sub}, {1'b1, j});
            chk({lk, fz}, {j == 8'h02, j == 8'h04});
            if (j[0] == 1'b0) setmax(8'h00, req, 1'b0);
        end
        $display("test security done");
        stop_test();
    end
endmodule : tb_max_address_limit_command
